//--- design/fpw_flash_guard.sv
// top: flash write guard with program store control, read scale and lock key
`timescale 1ns/100ps
module fpw_flash_guard (
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	input  wire logic         sfr_wr_i,
	input  wire logic         sfr_rd_i,
	input  wire logic [7:0]   sfr_addr_i,
	input  wire logic [7:0]   sfr_wdata_i,
	output logic [7:0]        sfr_rdata_o,
	input  wire logic         move_write_i,
	input  wire logic [15:0]  move_addr_i,
	input  wire logic [7:0]   move_data_i,
	output logic              ram_write_o,
	output logic [15:0]       ram_addr_o,
	output logic [7:0]        ram_data_o,
	output logic              flash_write_o,
	output logic              flash_erase_o,
	output logic [15:0]       flash_addr_o,
	output logic [7:0]        flash_data_o,
	output logic              read_one_shot_enable_o,
	output logic [1:0]        lock_state_o
);
	fpw_pkg::fpw_sfr_req_t    req;
	fpw_pkg::fpw_flash_cmd_t  cmd;
	fpw_pkg::fpw_lock_t       lock_state;
	logic                     store_write_enable;
	logic                     store_erase_enable;
	logic                     next_store_write_enable;
	logic                     next_store_erase_enable;
	logic [7:0]               flash_read_scale;
	logic [7:0]               next_flash_read_scale;
	logic [7:0]               next_rdata;
	logic                     key_write;
	logic                     flash_attempt;
	logic                     ram_write;
	logic                     next_flash_write;
	logic                     next_flash_erase;
	logic [15:0]              next_flash_addr;
	logic [7:0]               next_flash_data;

	// pack the register-bus access
	always_comb begin
		req.wr    = sfr_wr_i;
		req.rd    = sfr_rd_i;
		req.addr  = sfr_addr_i;
		req.wdata = sfr_wdata_i;
	end

	assign key_write = req.wr && (req.addr == fpw_pkg::ADDR_FLASH_LOCK_KEY);

	fpw_lock_fsm u_lock (
		.clk_i           (clk_i),
		.reset_i         (reset_i),
		.key_write_i     (key_write),
		.key_data_i      (req.wdata),
		.flash_attempt_i (flash_attempt),
		.state_o         (lock_state)
	);

	fpw_move_router u_router (
		.move_write_i    (move_write_i),
		.move_addr_i     (move_addr_i),
		.move_data_i     (move_data_i),
		.write_enable_i  (store_write_enable),
		.erase_enable_i  (store_erase_enable),
		.unlocked_i      (lock_state == fpw_pkg::LOCK_UNLOCKED),
		.ram_write_o     (ram_write),
		.flash_attempt_o (flash_attempt),
		.cmd_o           (cmd)
	);

	// next values of writable registers; upper control bits are dropped
	always_comb begin
		next_store_write_enable = store_write_enable;
		next_store_erase_enable = store_erase_enable;
		next_flash_read_scale   = flash_read_scale;
		if (req.wr && req.addr == fpw_pkg::ADDR_PROGRAM_STORE_CONTROL) begin
			next_store_write_enable = req.wdata[fpw_pkg::BIT_WRITE_ENABLE];
			next_store_erase_enable = req.wdata[fpw_pkg::BIT_ERASE_ENABLE];
		end
		if (req.wr && req.addr == fpw_pkg::ADDR_FLASH_READ_SCALE)
			next_flash_read_scale = req.wdata;
	end

	// read data mux; unmapped addresses read zero
	always_comb begin
		next_rdata = 8'h00;
		if (req.rd) begin
			case (req.addr)
				fpw_pkg::ADDR_PROGRAM_STORE_CONTROL:
					next_rdata = {6'h00, store_erase_enable, store_write_enable};
				fpw_pkg::ADDR_FLASH_READ_SCALE: next_rdata = flash_read_scale;
				fpw_pkg::ADDR_FLASH_LOCK_KEY: next_rdata = {6'h00, lock_state};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// flash command, no blank check before programming
	always_comb begin
		next_flash_write = cmd.write;
		next_flash_erase = cmd.erase;
		next_flash_addr  = cmd.addr;
		next_flash_data  = cmd.data;
	end

	// register everything; outputs come from flops
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			store_write_enable     <= fpw_pkg::RESET_PROGRAM_STORE_CONTROL[fpw_pkg::BIT_WRITE_ENABLE];
			store_erase_enable     <= fpw_pkg::RESET_PROGRAM_STORE_CONTROL[fpw_pkg::BIT_ERASE_ENABLE];
			flash_read_scale       <= fpw_pkg::RESET_FLASH_READ_SCALE;
			sfr_rdata_o            <= 8'h00;
			ram_write_o            <= 1'b0;
			ram_addr_o             <= 16'h0000;
			ram_data_o             <= 8'h00;
			flash_write_o          <= 1'b0;
			flash_erase_o          <= 1'b0;
			flash_addr_o           <= 16'h0000;
			flash_data_o           <= 8'h00;
			read_one_shot_enable_o <= fpw_pkg::RESET_FLASH_READ_SCALE[fpw_pkg::BIT_ONE_SHOT];
			lock_state_o           <= 2'b00;
		end else begin
			store_write_enable     <= next_store_write_enable;
			store_erase_enable     <= next_store_erase_enable;
			flash_read_scale       <= next_flash_read_scale;
			sfr_rdata_o            <= next_rdata;
			ram_write_o            <= ram_write;
			ram_addr_o             <= move_addr_i;
			ram_data_o             <= move_data_i;
			flash_write_o          <= next_flash_write;
			flash_erase_o          <= next_flash_erase;
			flash_addr_o           <= next_flash_addr;
			flash_data_o           <= next_flash_data;
			read_one_shot_enable_o <= next_flash_read_scale[fpw_pkg::BIT_ONE_SHOT];
			lock_state_o           <= lock_state; // mirror, one cycle behind
		end
	end
endmodule // fpw_flash_guard

//--- design/fpw_lock_fsm.sv
// two-key lock state machine
`timescale 1ns/100ps
module fpw_lock_fsm (
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic             key_write_i,
	input  wire logic [7:0]       key_data_i,
	input  wire logic             flash_attempt_i,
	output fpw_pkg::fpw_lock_t    state_o
);
	fpw_pkg::fpw_lock_t state;
	fpw_pkg::fpw_lock_t next_state;

	// next lock state from key writes and flash attempts
	always_comb begin
		next_state = state;
		case (state)
			fpw_pkg::LOCK_LOCKED: begin
				if (flash_attempt_i)
					next_state = fpw_pkg::LOCK_DISABLED;
				else if (key_write_i)
					next_state = (key_data_i == fpw_pkg::KEY_FIRST) ? fpw_pkg::LOCK_FIRST
						: fpw_pkg::LOCK_DISABLED;
			end
			fpw_pkg::LOCK_FIRST: begin
				if (flash_attempt_i)
					next_state = fpw_pkg::LOCK_DISABLED;
				else if (key_write_i)
					next_state = (key_data_i == fpw_pkg::KEY_SECOND) ? fpw_pkg::LOCK_UNLOCKED
						: fpw_pkg::LOCK_DISABLED;
			end
			fpw_pkg::LOCK_UNLOCKED: begin
				if (flash_attempt_i)
					next_state = fpw_pkg::LOCK_LOCKED;
				else if (key_write_i)
					next_state = fpw_pkg::LOCK_DISABLED;
			end
			fpw_pkg::LOCK_DISABLED: next_state = fpw_pkg::LOCK_DISABLED;
			default: next_state = fpw_pkg::LOCK_DISABLED;
		endcase
	end

	// lock state register
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i)
			state <= fpw_pkg::LOCK_LOCKED;
		else
			state <= next_state;
	end

	assign state_o = state;
endmodule // fpw_lock_fsm

//--- design/fpw_move_router.sv
// routes an external-move write to RAM or to a flash command
`timescale 1ns/100ps
module fpw_move_router (
	input  wire logic                 move_write_i,
	input  wire logic [15:0]          move_addr_i,
	input  wire logic [7:0]           move_data_i,
	input  wire logic                 write_enable_i,
	input  wire logic                 erase_enable_i,
	input  wire logic                 unlocked_i,
	output logic                      ram_write_o,
	output logic                      flash_attempt_o,
	output fpw_pkg::fpw_flash_cmd_t   cmd_o
);
	// decode target and operation
	always_comb begin
		ram_write_o     = move_write_i & ~write_enable_i;
		flash_attempt_o = move_write_i & write_enable_i;
		cmd_o.write     = flash_attempt_o & unlocked_i & ~erase_enable_i;
		cmd_o.erase     = flash_attempt_o & unlocked_i & erase_enable_i;
		cmd_o.addr      = move_addr_i;
		cmd_o.data      = erase_enable_i ? 8'h00 : move_data_i;
	end
endmodule // fpw_move_router

//--- design/fpw_pkg.sv
// package: register addresses, field positions, reset values and lock states
package fpw_pkg;
	localparam logic [7:0] ADDR_PROGRAM_STORE_CONTROL = 8'h8F;
	localparam logic [7:0] ADDR_FLASH_READ_SCALE      = 8'hB6;
	localparam logic [7:0] ADDR_FLASH_LOCK_KEY        = 8'hB7;
	localparam logic [7:0] RESET_PROGRAM_STORE_CONTROL = 8'h00;
	localparam logic [7:0] RESET_FLASH_READ_SCALE      = 8'h80;
	localparam logic [7:0] KEY_FIRST                   = 8'hA5;
	localparam logic [7:0] KEY_SECOND                  = 8'hF1;
	localparam int         BIT_WRITE_ENABLE            = 0;
	localparam int         BIT_ERASE_ENABLE            = 1;
	localparam int         BIT_ONE_SHOT                = 7;

	typedef enum logic [1:0] {
		LOCK_LOCKED   = 2'b00,
		LOCK_FIRST    = 2'b01,
		LOCK_UNLOCKED = 2'b10,
		LOCK_DISABLED = 2'b11
	} fpw_lock_t;

	// one register-bus write or read
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fpw_sfr_req_t;

	// one flash command toward the array
	typedef struct packed {
		logic        write;
		logic        erase;
		logic [15:0] addr;
		logic [7:0]  data;
	} fpw_flash_cmd_t;
endpackage

//--- dv/fpw_cpu_model.sv
// partner model: core issuing register and external-move writes
`timescale 1ns/100ps
module fpw_cpu_model (
	input  wire logic        clk_i,
	output logic             wr_o,
	output logic             rd_o,
	output logic [7:0]       addr_o,
	output logic [7:0]       wdata_o,
	output logic             mv_o,
	output logic [15:0]      maddr_o,
	output logic [7:0]       mdata_o
);
	initial {wr_o, rd_o, mv_o, addr_o, wdata_o, maddr_o, mdata_o} = '0;
	// one register access, held until its taking edge
	task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_o    <= w;
		rd_o    <= !w;
		addr_o  <= a;
		wdata_o <= d;
		@(posedge clk_i);
		wr_o    <= 1'b0;
		rd_o    <= 1'b0;
		wdata_o <= ~d; // released data never repeats
	endtask
	// external-move write, held until its taking edge
	task automatic move(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		mv_o    <= 1'b1;
		maddr_o <= a;
		mdata_o <= d;
		@(posedge clk_i);
		mv_o    <= 1'b0;
		mdata_o <= ~d;
	endtask
	// two keys in the required order
	task automatic unlock();
		sfr(1'b1, 8'hB7, 8'hA5);
		sfr(1'b1, 8'hB7, 8'hF1);
	endtask
endmodule // fpw_cpu_model

//--- dv/fpw_guard_sva.sv
// checker: port assertions for the flash write guard
`timescale 1ns/100ps
module fpw_guard_sva (
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic        sfr_rd_i,
	input wire logic [7:0]  sfr_addr_i,
	input wire logic [7:0]  sfr_rdata_o,
	input wire logic        move_write_i,
	input wire logic [15:0] move_addr_i,
	input wire logic [7:0]  move_data_i,
	input wire logic        ram_write_o,
	input wire logic        flash_write_o,
	input wire logic        flash_erase_o,
	input wire logic [15:0] flash_addr_o,
	input wire logic [7:0]  flash_data_o,
	input wire logic [1:0]  lock_state_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// register, routing and lock checks
	ctrl_upper_a: assert property (
		sfr_rd_i && sfr_addr_i == 8'h8F |=> sfr_rdata_o[7:2] == 6'h00) else $error("ctrl bits");
	route_excl_a: assert property (
		ram_write_o |-> !flash_write_o && !flash_erase_o) else $error("ram and flash");
	byte_cause_a: assert property (
		flash_write_o |-> $past(move_write_i) && flash_addr_o == $past(move_addr_i)
		&& flash_data_o == $past(move_data_i)) else $error("byte write");
	erase_data_a: assert property (
		flash_erase_o |-> !flash_write_o && flash_data_o == 8'h00
		&& flash_addr_o == $past(move_addr_i)) else $error("erase");
	key_order_a: assert property (
		lock_state_o == 2'b00 |=> lock_state_o != 2'b10) else $error("unlock order");
	op_relock_a: assert property (
		flash_write_o || flash_erase_o |-> ##[0:2] lock_state_o == 2'b00) else $error("relock");
	lock_stays_a: assert property (
		lock_state_o == 2'b11 |=> lock_state_o == 2'b11) else $error("lock left");
	locked_move_a: assert property (
		move_write_i && lock_state_o == 2'b11 |=> !flash_write_o && !flash_erase_o)
		else $error("locked op");
endmodule // fpw_guard_sva

bind fpw_flash_guard fpw_guard_sva i_sva (.*);

//--- dv/testbench.sv
// testbench: directed scenarios for the flash write guard
`timescale 1ns/100ps
module testbench;
	logic        clk_i, reset_i, sfr_wr_i, sfr_rd_i, move_write_i, ram_write_o;
	logic        flash_write_o, flash_erase_o, read_one_shot_enable_o;
	logic [1:0]  lock_state_o;
	logic [7:0]  sfr_addr_i, sfr_wdata_i, sfr_rdata_o, move_data_i, ram_data_o, flash_data_o;
	logic [15:0] move_addr_i, ram_addr_o, flash_addr_o;
	int          err_count = 0;
	int          cmp_count = 0;
	fpw_flash_guard i_dut (.*);
	fpw_cpu_model i_cpu (.clk_i(clk_i), .wr_o(sfr_wr_i), .rd_o(sfr_rd_i), .addr_o(sfr_addr_i),
		.wdata_o(sfr_wdata_i), .mv_o(move_write_i), .maddr_o(move_addr_i), .mdata_o(move_data_i));
	// 50 ns clock
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic do_reset();
		@(posedge clk_i);
		reset_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
	endtask
	// read a register, compare the data one cycle later
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		i_cpu.sfr(1'b0, a, 8'h00);
		#1 check({8'h00, sfr_rdata_o}, {8'h00, e});
	endtask
	// move write, compare ram, program and erase pulses
	task automatic mv(input logic [15:0] a, input logic [7:0] d, input logic [2:0] e);
		i_cpu.move(a, d);
		#1 check({13'h0000, ram_write_o, flash_write_o, flash_erase_o}, {13'h0000, e});
	endtask
	task automatic t_regs();
		rd(8'h8F, 8'h00);
		rd(8'hB6, 8'h80);
		rd(8'hB7, 8'h00);
		rd(8'h3C, 8'h00);
		check({15'h0000, read_one_shot_enable_o}, 16'h0001);
		i_cpu.sfr(1'b1, 8'h8F, 8'hFC);
		rd(8'h8F, 8'h00);
		i_cpu.sfr(1'b1, 8'hB6, 8'h00);
		rd(8'hB6, 8'h00);
		check({15'h0000, read_one_shot_enable_o}, 16'h0000);
		i_cpu.sfr(1'b1, 8'hB6, 8'h80);
	endtask
	task automatic t_ram();
		mv(16'h0123, 8'h3C, 3'b100);
		check(ram_addr_o, 16'h0123);
		check({8'h00, ram_data_o}, 16'h003C);
		rd(8'hB7, 8'h00);
	endtask
	task automatic t_flash();
		for (int i = 0; i < 2; i++) begin
			i_cpu.unlock();
			rd(8'hB7, 8'h02);
			i_cpu.sfr(1'b1, 8'h8F, 8'h03);
			mv(16'h1234, i ? 8'hFF : 8'h00, 3'b001);
			check(flash_addr_o, 16'h1234);
			check({8'h00, flash_data_o}, 16'h0000);
		end
		i_cpu.sfr(1'b1, 8'hB7, 8'hA5);
		rd(8'hB7, 8'h01);
		i_cpu.sfr(1'b1, 8'hB7, 8'hF1);
		i_cpu.sfr(1'b1, 8'h8F, 8'h01);
		mv(16'h1235, 8'h5A, 3'b010);
		check(flash_addr_o, 16'h1235);
		check({8'h00, flash_data_o}, 16'h005A);
		rd(8'hB7, 8'h00);
	endtask
	task automatic t_lock();
		mv(16'h0040, 8'h11, 3'b000);
		rd(8'hB7, 8'h03);
		do_reset();
		rd(8'hB7, 8'h00);
		i_cpu.sfr(1'b1, 8'hB7, 8'h5B);
		i_cpu.unlock();
		i_cpu.sfr(1'b1, 8'h8F, 8'h01);
		mv(16'h0040, 8'h11, 3'b000);
		rd(8'hB7, 8'h03);
		do_reset();
		i_cpu.sfr(1'b1, 8'hB7, 8'hA5);
		i_cpu.sfr(1'b1, 8'hB7, 8'hA5);
		rd(8'hB7, 8'h03);
	endtask
	initial begin
		reset_i = 1'b1;
		do_reset();
		t_regs();
		t_ram();
		t_flash();
		t_lock();
		end_sim();
	end
endmodule // testbench
